// >>> common/serial_config_source_cfg.svh
`ifndef SERIAL_CONFIG_SOURCE_CFG_SVH
`define SERIAL_CONFIG_SOURCE_CFG_SVH

// stored bitstream
`define CFG_ADDR_W        10
`define CFG_DEPTH         1024
`define CFG_ADDR_ZERO     10'h000
`define CFG_ADDR_ONE      10'h001
`define CFG_LAST_ADDR     10'h3ff

// timing
`define CFG_SYS_PERIOD_NS 50
`define CFG_LINK_PERIOD_NS 400
`define CFG_HALF_CYCLES   (`CFG_LINK_PERIOD_NS / (2 * `CFG_SYS_PERIOD_NS))
`define CFG_DIV_W         3
`define CFG_POR_NS        2000
`define CFG_POR_CYCLES    \
   ((`CFG_POR_NS + `CFG_SYS_PERIOD_NS - 1) / `CFG_SYS_PERIOD_NS)
`define CFG_INIT_LOW_NS   1000
`define CFG_INIT_LOW_CYCLES \
   ((`CFG_INIT_LOW_NS + `CFG_SYS_PERIOD_NS - 1) / `CFG_SYS_PERIOD_NS)
`define CFG_CNT_W         6

// synchroniser vector layout
`define CFG_SY_W          6
`define CFG_SY_OE         0
`define CFG_SY_CS_N       1
`define CFG_SY_MODE_LO    2
`define CFG_SY_MODE_HI    3
`define CFG_SY_RECFG      4
`define CFG_SY_CASC       5
`define CFG_SY_RESET      6'h00

`endif

// >>> common/serial_config_source_pkg.sv
package serial_config_source_pkg;

   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_IDLE  = 4'h2,
      ST_RUN   = 4'h4,
      ST_DONE  = 4'h8
   } xfer_state_t;

   typedef enum logic [2:0] {
      IC_IDLE = 3'h1,
      IC_LOW  = 3'h2,
      IC_HIGH = 3'h4
   } init_state_t;

   typedef enum logic [1:0] {
      PROTO_P0 = 2'h0,
      PROTO_P1 = 2'h1,
      PROTO_P2 = 2'h2,
      PROTO_P3 = 2'h3
   } proto_t;

endpackage : serial_config_source_pkg

// >>> logic/config_bit_store.sv
`timescale 1ns/100ps
`include "serial_config_source_cfg.svh"

module config_bit_store (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   load_en,
   input  wire logic [`CFG_ADDR_W-1:0] load_addr,
   input  wire logic                   load_bit,
   input  wire logic [`CFG_ADDR_W-1:0] rd_addr,
   output logic                        rd_bit
);

   logic mem [`CFG_DEPTH];
   logic rd_bit_ff;

   always_ff @(posedge sys_clk) begin
      if (load_en) begin
         mem[load_addr] <= load_bit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_bit_ff <= 1'b0;
      end else begin
         rd_bit_ff <= mem[rd_addr];
      end
   end

   assign rd_bit = rd_bit_ff;

endmodule : config_bit_store

// >>> logic/serial_config_source.sv
`timescale 1ns/100ps
`include "serial_config_source_cfg.svh"

// Function
// [RULE1] output-enable low clears the address counter and floats data.
// [RULE2] chip select high after reset pulse keeps counter stopped, data floating.
// [RULE3] chip select low with output-enable high runs counter and drives data.
// [RULE4] any later output-enable low resets counter and floats data always.
// [RULE5] both controls active gate data buffer, counter and oscillator.
// [RULE6] rising output-enable latches operating mode and target protocol.
// [RULE7] after last bit and cascade select low, data output floats.
// [RULE8] output-enable is open drain: pull low or release, level sensed.
// [RULE9] jtag request pulls reload line low, then drives it high.
// [RULE10] leaving the jtag request state releases the reload line.
// [RULE11] transfer runs alone on chip select, output-enable and clock.
// [RULE12] only cascade-capable parts assert cascade select when exhausted.
// [RULE13] serial clock comes from internal oscillator, data shifts with it.
// [RULE14] bitstream leaves on the single data pin to the target.
// [RULE15] one bit per clock cycle, address rising by one each cycle.

module serial_config_source (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   oe_in,
   output logic                        oe_out,
   output logic                        oe_en,
   input  wire logic                   chip_select_n,
   input  wire logic [1:0]             mode_sel,
   input  wire logic                   cascade_strap,
   input  wire logic                   jtag_reconfig,
   input  wire logic                   load_en,
   input  wire logic [`CFG_ADDR_W-1:0] load_addr,
   input  wire logic                   load_bit,
   output logic                        dclk_out,
   output logic                        target_serial_input,
   output logic                        target_serial_input_en,
   output logic                        cascade_select_low,
   output logic                        init_conf_out,
   output logic                        init_conf_en,
   output serial_config_source_pkg::proto_t active_proto
);

   function automatic logic [`CFG_CNT_W-1:0] cnt_inc(
      input logic [`CFG_CNT_W-1:0] val
   );
      cnt_inc = val + `CFG_CNT_W'(1);
   endfunction : cnt_inc

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [`CFG_SY_W-1:0] pins_raw;
   logic [`CFG_SY_W-1:0] meta_ff;
   logic [`CFG_SY_W-1:0] sync_ff;
   logic                 oe_s;
   logic                 cs_n_s;
   logic [1:0]           mode_s;
   logic                 recfg_s;
   logic                 casc_s;

   assign pins_raw = {cascade_strap, jtag_reconfig, mode_sel,
                      chip_select_n, oe_in};

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_ff <= `CFG_SY_RESET;
         sync_ff <= `CFG_SY_RESET;
      end else begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
      end
   end

   assign oe_s    = sync_ff[`CFG_SY_OE];      // RULE8
   assign cs_n_s  = sync_ff[`CFG_SY_CS_N];
   assign mode_s  = sync_ff[`CFG_SY_MODE_HI:`CFG_SY_MODE_LO];
   assign recfg_s = sync_ff[`CFG_SY_RECFG];
   assign casc_s  = sync_ff[`CFG_SY_CASC];

   ////////////////////////////////////////////////////////////////////////
   // power-on hold of the open-drain output-enable line

   logic [`CFG_CNT_W-1:0] por_cnt_ff;
   logic [`CFG_CNT_W-1:0] nxt_por_cnt;
   logic                  por_active;

   assign por_active = (por_cnt_ff != `CFG_CNT_W'(`CFG_POR_CYCLES));

   always_comb begin
      nxt_por_cnt = por_cnt_ff;
      if (por_active) begin
         nxt_por_cnt = cnt_inc(por_cnt_ff);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         por_cnt_ff <= '0;
      end else begin
         por_cnt_ff <= nxt_por_cnt;
      end
   end

   // only ever pulls low or releases
   assign oe_out = 1'b0;                          // RULE8
   assign oe_en  = por_active;                    // RULE8

   ////////////////////////////////////////////////////////////////////////
   // mode capture on output-enable rising

   serial_config_source_pkg::proto_t proto_ff;
   serial_config_source_pkg::proto_t nxt_proto;
   logic                             oe_prev_ff;
   logic                             oe_rise;

   assign oe_rise = oe_s && !oe_prev_ff;

   always_comb begin
      nxt_proto = proto_ff;
      if (oe_rise) begin
         nxt_proto = serial_config_source_pkg::proto_t'(mode_s); // RULE6
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         proto_ff   <= serial_config_source_pkg::PROTO_P0;
         oe_prev_ff <= 1'b0;
      end else begin
         proto_ff   <= nxt_proto;
         oe_prev_ff <= oe_s;
      end
   end

   assign active_proto = proto_ff;

   ////////////////////////////////////////////////////////////////////////
   // transfer engine: counter, oscillator, data gating

   serial_config_source_pkg::xfer_state_t state_ff;
   serial_config_source_pkg::xfer_state_t nxt_state;
   logic [`CFG_ADDR_W-1:0] addr_ff;
   logic [`CFG_ADDR_W-1:0] nxt_addr;
   logic [`CFG_DIV_W-1:0]  div_ff;
   logic [`CFG_DIV_W-1:0]  nxt_div;
   logic                   dclk_ff;
   logic                   nxt_dclk;
   logic                   osc_en;
   logic                   div_end;
   logic                   dclk_rise;
   logic                   store_bit;
   logic                   last_ff;
   logic                   nxt_last;

   assign osc_en    = (state_ff == serial_config_source_pkg::ST_RUN)
                      && oe_s && !cs_n_s;                       // RULE5
   assign div_end   = (div_ff == `CFG_DIV_W'(`CFG_HALF_CYCLES - 1));
   assign dclk_rise = osc_en && div_end && !dclk_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_addr  = addr_ff;
      nxt_div   = div_ff;
      nxt_dclk  = dclk_ff;
      nxt_last  = last_ff;
      if (osc_en) begin
         if (div_end) begin
            nxt_div  = '0;
            nxt_dclk = !dclk_ff;                               // RULE13
         end else begin
            nxt_div = div_ff + `CFG_DIV_W'(1);
         end
      end
      unique case (state_ff)
         serial_config_source_pkg::ST_RESET: begin
            nxt_addr = `CFG_ADDR_ZERO;
            nxt_div  = '0;
            nxt_dclk = 1'b0;
            if (oe_s) begin
               nxt_state = cs_n_s ? serial_config_source_pkg::ST_IDLE
                                  : serial_config_source_pkg::ST_RUN;
            end
         end
         serial_config_source_pkg::ST_IDLE: begin
            if (!cs_n_s) begin
               nxt_state = serial_config_source_pkg::ST_RUN;     // RULE3
            end
         end
         serial_config_source_pkg::ST_RUN: begin
            if (last_ff) begin
               // last bit stands one cycle past its clock rise
               nxt_state = serial_config_source_pkg::ST_DONE;    // RULE7
            end else if (cs_n_s) begin
               nxt_state = serial_config_source_pkg::ST_IDLE;    // RULE5
            end else if (dclk_rise) begin
               if (addr_ff == `CFG_LAST_ADDR) begin
                  nxt_last = 1'b1;                               // RULE7
               end else begin
                  nxt_addr = addr_ff + `CFG_ADDR_ONE;            // RULE15
               end
            end
         end
         serial_config_source_pkg::ST_DONE: begin
            nxt_state = serial_config_source_pkg::ST_DONE;
         end
      endcase
      // output-enable low overrides everything
      if (!oe_s) begin
         nxt_state = serial_config_source_pkg::ST_RESET;         // RULE4
         nxt_addr  = `CFG_ADDR_ZERO;                             // RULE1
         nxt_div   = '0;
         nxt_dclk  = 1'b0;
         nxt_last  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_ff <= serial_config_source_pkg::ST_RESET;
         addr_ff  <= `CFG_ADDR_ZERO;
         div_ff   <= '0;
         dclk_ff  <= 1'b0;
         last_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;                                  // RULE11
         addr_ff  <= nxt_addr;
         div_ff   <= nxt_div;
         dclk_ff  <= nxt_dclk;
         last_ff  <= nxt_last;
      end
   end

   config_bit_store u_store (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .load_en   (load_en),
      .load_addr (load_addr),
      .load_bit  (load_bit),
      .rd_addr   (addr_ff),
      .rd_bit    (store_bit)
   );

   assign dclk_out               = dclk_ff;                      // RULE13
   assign target_serial_input    = store_bit;                    // RULE14
   assign target_serial_input_en =
      (state_ff == serial_config_source_pkg::ST_RUN);            // RULE2
   assign cascade_select_low     =
      !((state_ff == serial_config_source_pkg::ST_DONE) && casc_s); // RULE12

   ////////////////////////////////////////////////////////////////////////
   // jtag-triggered reload request

   serial_config_source_pkg::init_state_t ic_ff;
   serial_config_source_pkg::init_state_t nxt_ic;
   logic [`CFG_CNT_W-1:0] ic_cnt_ff;
   logic [`CFG_CNT_W-1:0] nxt_ic_cnt;

   always_comb begin
      nxt_ic     = ic_ff;
      nxt_ic_cnt = ic_cnt_ff;
      unique case (ic_ff)
         serial_config_source_pkg::IC_IDLE: begin
            nxt_ic_cnt = '0;
            if (recfg_s) begin
               nxt_ic = serial_config_source_pkg::IC_LOW;        // RULE9
            end
         end
         serial_config_source_pkg::IC_LOW: begin
            nxt_ic_cnt = cnt_inc(ic_cnt_ff);
            if (!recfg_s) begin
               nxt_ic = serial_config_source_pkg::IC_IDLE;       // RULE10
            end else if (ic_cnt_ff ==
                         `CFG_CNT_W'(`CFG_INIT_LOW_CYCLES - 1)) begin
               nxt_ic = serial_config_source_pkg::IC_HIGH;       // RULE9
            end
         end
         serial_config_source_pkg::IC_HIGH: begin
            if (!recfg_s) begin
               nxt_ic = serial_config_source_pkg::IC_IDLE;       // RULE10
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ic_ff     <= serial_config_source_pkg::IC_IDLE;
         ic_cnt_ff <= '0;
      end else begin
         ic_ff     <= nxt_ic;
         ic_cnt_ff <= nxt_ic_cnt;
      end
   end

   assign init_conf_en  = (ic_ff != serial_config_source_pkg::IC_IDLE);
   assign init_conf_out = (ic_ff == serial_config_source_pkg::IC_HIGH);

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_oe_low_clears;
      !oe_s |=> (addr_ff == `CFG_ADDR_ZERO) && !target_serial_input_en;
   endproperty
   a_oe_low_clears: assert property (p_oe_low_clears) // RULE1
      else $error("output-enable low did not clear counter");

   property p_cs_high_holds;
      (state_ff == serial_config_source_pkg::ST_IDLE) && oe_s && cs_n_s
      |=> $stable(addr_ff) && !target_serial_input_en;
   endproperty
   a_cs_high_holds: assert property (p_cs_high_holds) // RULE2
      else $error("counter moved while chip select high");

   property p_cs_low_runs;
      (state_ff == serial_config_source_pkg::ST_IDLE) && oe_s && !cs_n_s
      |=> target_serial_input_en;
   endproperty
   a_cs_low_runs: assert property (p_cs_low_runs) // RULE3
      else $error("data not driven after chip select low");

   property p_oe_low_aborts;
      (state_ff == serial_config_source_pkg::ST_RUN) && !oe_s
      |=> (state_ff == serial_config_source_pkg::ST_RESET)
          && !target_serial_input_en;
   endproperty
   a_oe_low_aborts: assert property (p_oe_low_aborts) // RULE4
      else $error("transfer not aborted by output-enable low");

   property p_osc_gated;
      !(oe_s && !cs_n_s)
      |=> ($past(oe_s) ? $stable(dclk_ff) : !dclk_ff);
   endproperty
   a_osc_gated: assert property (p_osc_gated) // RULE5
      else $error("serial clock ran while gated off");

   property p_mode_latch;
      $rose(oe_s) |=> (proto_ff == $past(mode_s));
   endproperty
   a_mode_latch: assert property (p_mode_latch) // RULE6
      else $error("mode not captured on output-enable rise");

   property p_done_floats;
      (state_ff == serial_config_source_pkg::ST_DONE)
      |-> !target_serial_input_en && (cascade_select_low == !casc_s);
   endproperty
   a_done_floats: assert property (p_done_floats) // RULE7
      else $error("data driven or cascade wrong after exhaustion");

   property p_por_release;
      $fell(oe_en) |-> $past(por_cnt_ff) ==
                       `CFG_CNT_W'(`CFG_POR_CYCLES - 1);
   endproperty
   a_por_release: assert property (p_por_release) // RULE8
      else $error("output-enable released at wrong time");

   property p_reload_low;
      $rose(recfg_s) && (ic_ff == serial_config_source_pkg::IC_IDLE)
      |=> init_conf_en && !init_conf_out;
   endproperty
   a_reload_low: assert property (p_reload_low) // RULE9
      else $error("reload line not pulled low");

   property p_reload_release;
      $fell(recfg_s) |=> !init_conf_en;
   endproperty
   a_reload_release: assert property (p_reload_release) // RULE10
      else $error("reload line not released");

   property p_addr_step;
      dclk_rise && (addr_ff != `CFG_LAST_ADDR) && !cs_n_s
      |=> addr_ff == $past(addr_ff) + `CFG_ADDR_ONE;
   endproperty
   a_addr_step: assert property (p_addr_step) // RULE15
      else $error("address did not step on serial clock");

endmodule : serial_config_source

// >>> bench/config_target_model.sv
`timescale 1ns/100ps

// configured device: pulls output-enable, answers with chip select
module config_target_model (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        dclk,
   input  wire logic        data_line,
   input  wire logic        oe_line,
   input  wire logic        nconfig_line,
   input  wire logic        oe_req,
   input  wire logic        cs_hold,
   output logic             oe_pull,
   output logic             cs_n,
   output logic             rx_valid,
   output logic             rx_bit,
   output logic [10:0]      rx_count
);
   logic        dclk_ff;
   logic [10:0] cnt_ff;

   // pull low only, never drive high
   assign oe_pull  = oe_req | ~nconfig_line;
   // chip select low while cs_hold is low, until the whole stream is in
   assign cs_n     = cs_hold | (cnt_ff == 11'h400);
   assign rx_count = cnt_ff;

   always @(posedge sys_clk) begin
      dclk_ff  <= dclk;
      rx_valid <= 1'b0;
      if (reset || !oe_line) begin
         cnt_ff <= 11'h000;
      end else if (dclk && !dclk_ff && cnt_ff != 11'h400) begin
         rx_valid <= 1'b1;
         rx_bit   <= data_line;
         cnt_ff   <= cnt_ff + 11'h001;
      end
   end
endmodule : config_target_model

// >>> bench/serial_config_source_test.sv
`timescale 1ns/100ps

module serial_config_source_test;
   logic sys_clk, reset, oe_in, oe_out, oe_en, chip_select_n, cascade_strap;
   logic jtag_reconfig, load_en, load_bit, dclk_out, tsi, tsi_en;
   logic cascade_select_low, init_conf_out, init_conf_en;
   logic oe_req, cs_hold, oe_pull, rx_valid, rx_bit, data_line, nconfig;
   logic [1:0]  mode_sel;
   logic [9:0]  load_addr;
   logic [10:0] rx_count;
   serial_config_source_pkg::proto_t active_proto;
   int num_errors = 0;
   int checked = 0;

   // open-drain output-enable with pull-up, floating data shows inverse
   assign oe_in     = ~(oe_en | oe_pull);
   assign data_line = tsi_en ? tsi : ~tsi;
   assign nconfig   = init_conf_en ? init_conf_out : 1'b1;

   serial_config_source serial_config_source_i (
      .sys_clk(sys_clk), .reset(reset), .oe_in(oe_in), .oe_out(oe_out),
      .oe_en(oe_en), .chip_select_n(chip_select_n), .mode_sel(mode_sel),
      .cascade_strap(cascade_strap), .jtag_reconfig(jtag_reconfig),
      .load_en(load_en), .load_addr(load_addr), .load_bit(load_bit),
      .dclk_out(dclk_out), .target_serial_input(tsi),
      .target_serial_input_en(tsi_en),
      .cascade_select_low(cascade_select_low),
      .init_conf_out(init_conf_out), .init_conf_en(init_conf_en),
      .active_proto(active_proto));

   config_target_model config_target_model_i (
      .sys_clk(sys_clk), .reset(reset), .dclk(dclk_out),
      .data_line(data_line), .oe_line(oe_in), .nconfig_line(nconfig),
      .oe_req(oe_req), .cs_hold(cs_hold), .oe_pull(oe_pull),
      .cs_n(chip_select_n), .rx_valid(rx_valid), .rx_bit(rx_bit),
      .rx_count(rx_count));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic pat(input logic [9:0] a);
      return ^(a & 10'h1b3) ^ a[9];
   endfunction : pat

   task check(input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task summarize();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task wait_rx(input int n);
      int k;
      for (k = 0; k < 9000 && !(rx_count >= n); k++) @(negedge sys_clk);
      check(11'(rx_count >= n), 11'h001);
   endtask : wait_rx

   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1) begin
         check(11'(rx_bit), 11'(pat(rx_count[9:0] - 10'h001)));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task t_por();
      int n;
      @(negedge sys_clk);
      check(11'(oe_en), 11'h001);
      check(11'(oe_out), 11'h000);
      check(11'(tsi_en), 11'h000);
      check(11'(cascade_select_low), 11'h001);
      check(11'(init_conf_en), 11'h000);
      for (n = 0; n < 80 && oe_en !== 1'b0; n++) @(negedge sys_clk);
      check(11'(n >= 38 && n <= 42), 11'h001);
   endtask : t_por

   task load_all();
      int a;
      for (a = 0; a < 1024; a++) begin
         @(posedge sys_clk);
         load_en   <= 1'b1;
         load_addr <= 10'(a);
         load_bit  <= pat(10'(a));
      end
      @(posedge sys_clk) load_en <= 1'b0;
   endtask : load_all

   task t_hold();
      int k;
      logic moved;
      moved = 1'b0;
      @(posedge sys_clk) oe_req <= 1'b0;
      repeat (48) begin
         @(negedge sys_clk);
         moved = moved | dclk_out | tsi_en;
      end
      check(11'(moved), 11'h000);
      @(posedge sys_clk) cs_hold <= 1'b0;
      for (k = 0; k < 20 && tsi_en !== 1'b1; k++) @(negedge sys_clk);
      check(11'(tsi_en), 11'h001);
      for (k = 0; k < 20 && dclk_out !== 1'b1; k++) @(negedge sys_clk);
      for (k = 0; k < 20 && dclk_out !== 1'b0; k++) @(negedge sys_clk);
      for (k = 0; k < 20 && dclk_out !== 1'b1; k++) @(negedge sys_clk);
      check(11'(k), 11'h004);
      wait_rx(8);
   endtask : t_hold

   task t_full(input logic [1:0] m, input logic strap);
      int k;
      @(posedge sys_clk);
      mode_sel      <= m;
      cascade_strap <= strap;
      oe_req        <= 1'b1;
      repeat (8) @(posedge sys_clk);
      oe_req <= 1'b0;
      for (k = 0; k < 9000 && chip_select_n !== 1'b1; k++) @(negedge sys_clk);
      repeat (4) @(negedge sys_clk);
      check(rx_count, 11'h400);
      check(11'(tsi_en), 11'h000);
      check(11'(cascade_select_low), 11'(!strap));
      check(11'(active_proto), 11'(m));
   endtask : t_full

   task t_pause();
      int c;
      logic d, moved;
      @(posedge sys_clk) oe_req <= 1'b1;
      repeat (8) @(posedge sys_clk);
      oe_req <= 1'b0;
      wait_rx(100);
      @(posedge sys_clk) cs_hold <= 1'b1;
      repeat (6) @(negedge sys_clk);
      check(11'(tsi_en), 11'h000);
      c = rx_count;
      d = dclk_out;
      moved = 1'b0;
      repeat (32) begin
         @(negedge sys_clk);
         moved = moved | (dclk_out !== d);
      end
      check(11'(moved), 11'h000);
      check(rx_count, 11'(c));
      @(posedge sys_clk) cs_hold <= 1'b0;
      wait_rx(c + 40);
      @(posedge sys_clk) oe_req <= 1'b1;
      repeat (5) @(negedge sys_clk);
      check(11'(tsi_en), 11'h000);
      check(11'(dclk_out), 11'h000);
      check(11'(chip_select_n), 11'h000);
      @(posedge sys_clk) oe_req <= 1'b0;
      wait_rx(16);
   endtask : t_pause

   task t_reload();
      int k, n;
      @(posedge sys_clk) jtag_reconfig <= 1'b1;
      for (k = 0; k < 8 && init_conf_en !== 1'b1; k++) @(negedge sys_clk);
      check(11'(init_conf_out), 11'h000);
      repeat (10) @(negedge sys_clk);
      check(11'(tsi_en), 11'h000);
      for (n = 10; n < 60 && nconfig !== 1'b1; n++) @(negedge sys_clk);
      check(11'(n >= 19 && n <= 21), 11'h001);
      check(11'(init_conf_en), 11'h001);
      @(posedge sys_clk) jtag_reconfig <= 1'b0;
      for (k = 0; k < 8 && init_conf_en !== 1'b0; k++) @(negedge sys_clk);
      check(11'(init_conf_en), 11'h000);
      wait_rx(16);
   endtask : t_reload

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      summarize();
   end

   initial begin
      int i;
      reset = 1'b1;
      cascade_strap = 1'b0;
      jtag_reconfig = 1'b0;
      load_en = 1'b0;
      load_addr = 10'h000;
      load_bit = 1'b0;
      mode_sel = 2'h0;
      oe_req = 1'b1;
      cs_hold = 1'b1;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      t_por();
      load_all();
      t_hold();
      for (i = 0; i < 4; i++) t_full(2'(i), i[0]);
      t_pause();
      t_reload();
      summarize();
   end
endmodule : serial_config_source_test
